// ---- rtl/fpm_mapper.v ----
// Summary of operation
// - stall line held low stalls CPU clock
// - trap line low requests protection trap
// - ring bits driven only while transferring
// - decode fetch start, end, indirection, zero
// - cache of direct descriptor fields kept
// - tag compared with segment, and with page for paged descriptors only
// - segment descriptor offset is low eleven bits
// - page descriptor offset is low seven bits
// - physical address is base plus offset
// - limit below offset flags an error
// - permission or ring failure flags an error
// - control-store decode finds call, return, special
// - return 13 high bits of mapped address
// - effective ring loaded from current ring at fetch start and end
`timescale 1ns/1ps
`default_nettype none
`include "fpm_consts.vh"

module fpm_mapper (
  input wire clock,
  input wire resetn,
  input wire ref_valid,
  input wire [`FPM_VA_W-1:0] virt_addr_in,
  input wire req_read,
  input wire req_write,
  input wire req_exec,
  input wire [1:0] cur_ring,
  input wire fetch_ctl_select,
  input wire fetch_func_code0,
  input wire fetch_func_code1,
  input wire fetch_func_code2,
  input wire [`FPM_CS_W-1:0] control_store_addr,
  input wire ring_drive,
  input wire ring_load,
  input wire ring_xfer_bit_hi_in,
  output wire ring_xfer_bit_hi_out,
  output wire ring_xfer_bit_hi_oe,
  input wire ring_xfer_bit_lo_in,
  output wire ring_xfer_bit_lo_out,
  output wire ring_xfer_bit_lo_oe,
  input wire desc_wr_en,
  input wire [`FPM_IDX_W-1:0] desc_wr_index,
  input wire [`FPM_ENT_W-1:0] desc_wr_data,
  input wire pm_resolve,
  input wire pm_trap_req,
  input wire clock_stall_n_in,
  output reg clock_stall_n_out,
  output reg clock_stall_n_oe,
  input wire trap_request_n_in,
  output reg trap_request_n_out,
  output reg trap_request_n_oe,
  output reg [`FPM_MAP_W-1:0] mapped_addr_out,
  output reg map_valid,
  output reg tag_equal,
  output reg miss_req,
  output reg limit_err,
  output reg perm_err,
  output reg [1:0] eff_ring_out,
  output reg [1:0] caller_ring_out,
  output reg in_fetch,
  output reg stall_seen,
  output reg trap_seen,
  output reg call_step,
  output reg return_step,
  output reg special_step
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [1:0] fpm_ring_max(input [1:0] a, input [1:0] b);
    fpm_ring_max = (a > b) ? a : b;
  endfunction

  // ----------------------------------------------------------------
  // state machine codes
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_LOOK = 3'b010;
  localparam ST_MISS = 3'b100;

  reg [2:0] state_reg, state_next;
  reg [`FPM_VA_W-1:0] va_reg;
  reg rd_reg, wr_reg, ex_reg;
  reg [1:0] eff_ring_reg, eff_ring_next;
  reg fetch_reg, fetch_next;
  reg [1:0] caller_ring_reg;
  reg [1:0] xfer_out_reg;
  reg xfer_oe_reg;

  wire [`FPM_ENT_W-1:0] ent;
  wire [3:0] fctl;
  wire [1:0] xfer_in;
  wire fw_call, fw_return, fw_special;

  assign fctl = {fetch_ctl_select, fetch_func_code0, fetch_func_code1, fetch_func_code2};
  assign xfer_in = {ring_xfer_bit_hi_in, ring_xfer_bit_lo_in};

  // ----------------------------------------------------------------
  // descriptor cache and firmware decode
  // ----------------------------------------------------------------
  // read is addressed straight from the pins so the entry is ready one edge later
  fpm_desc_mem u_mem (
    .clock(clock),
    .resetn(resetn),
    .wr_en(desc_wr_en),
    .wr_addr(desc_wr_index),
    .wr_data(desc_wr_data),
    .rd_addr(virt_addr_in[`FPM_IDX_LSB+`FPM_IDX_W-1:`FPM_IDX_LSB]),
    .rd_data(ent)
  );

  fpm_fw_detect u_fw (
    .clock(clock),
    .resetn(resetn),
    .cs_addr(control_store_addr),
    .call_step(fw_call),
    .return_step(fw_return),
    .special_step(fw_special)
  );

  // ----------------------------------------------------------------
  // lookup datapath
  // ----------------------------------------------------------------
  wire ent_valid = ent[`FPM_ENT_VALID];
  wire ent_paged = ent[`FPM_ENT_PAGED];
  wire [3:0] ent_seghi = ent[`FPM_ENT_SEGHI_HI:`FPM_ENT_SEGHI_LO];
  wire [3:0] ent_page = ent[`FPM_ENT_PAGE_HI:`FPM_ENT_PAGE_LO];
  wire [`FPM_MAP_W-1:0] ent_base = ent[`FPM_ENT_BASE_HI:`FPM_ENT_BASE_LO];
  wire [`FPM_SEG_OFS_W-1:0] ent_limit = ent[`FPM_ENT_LIM_HI:`FPM_ENT_LIM_LO];
  wire [1:0] ent_ring = ent[`FPM_ENT_RING_HI:`FPM_ENT_RING_LO];

  wire seg_match = (ent_seghi == va_reg[`FPM_VA_W-1:`FPM_SEGHI_LSB]);
  wire page_match = (ent_page == va_reg[`FPM_IDX_LSB-1:`FPM_PAGE_LSB]);
  // a segment descriptor covers every page, so the page field is ignored
  wire hit = ent_valid & seg_match & (page_match | ~ent_paged);

  reg [`FPM_SEG_OFS_W-1:0] offset;
  always @* begin
    if (ent_paged) begin
      offset = {{(`FPM_SEG_OFS_W-`FPM_PAGE_OFS_W){1'b0}},
                va_reg[`FPM_PAGE_OFS_W-1:0]};
    end else begin
      offset = va_reg[`FPM_SEG_OFS_W-1:0];
    end
  end

  // carry out of the top bit is dropped: the mapped space is 13 bits wide
  wire [`FPM_MAP_W-1:0] phys = ent_base + {{(`FPM_MAP_W-`FPM_SEG_OFS_W){1'b0}}, offset};
  wire lim_fail = (ent_limit < offset);

  // during fetch the check ring is the CPU ring, not a raised one
  wire [1:0] check_ring = fetch_reg ? cur_ring : eff_ring_reg;
  wire ring_fail = (check_ring > ent_ring);
  wire rwx_fail = (rd_reg & ~ent[`FPM_ENT_READ]) |
                  (wr_reg & ~ent[`FPM_ENT_WRITE]) |
                  (ex_reg & ~ent[`FPM_ENT_EXEC]);
  wire perm_fail = ring_fail | rwx_fail;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ref_valid) begin
          state_next = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (!hit) begin
          state_next = ST_MISS;
        end else if (!ref_valid) begin
          state_next = ST_IDLE;
        end
      end
      ST_MISS: begin
        if (pm_resolve) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  wire take = ref_valid & ((state_reg == ST_IDLE) | ((state_reg == ST_LOOK) & hit));

  always @(posedge clock) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      va_reg <= {`FPM_VA_W{1'b0}};
      {rd_reg, wr_reg, ex_reg} <= 3'b000;
    end else begin
      state_reg <= state_next;
      if (take) begin
        va_reg <= virt_addr_in;
        {rd_reg, wr_reg, ex_reg} <= {req_read, req_write, req_exec};
      end
    end
  end

  // ----------------------------------------------------------------
  // lookup results
  // ----------------------------------------------------------------
  wire look = (state_reg == ST_LOOK);

  always @(posedge clock) begin
    if (!resetn) begin
      mapped_addr_out <= `FPM_MAP_RST;
      map_valid <= 1'b0;
      tag_equal <= 1'b0;
      miss_req <= 1'b0;
      limit_err <= 1'b0;
      perm_err <= 1'b0;
    end else begin
      map_valid <= look & hit & ~lim_fail & ~perm_fail;
      tag_equal <= look & hit;
      miss_req <= look & ~hit;
      limit_err <= look & hit & lim_fail;
      perm_err <= look & hit & perm_fail;
      // address is only updated by a clean hit, so a miss never shows a new one
      if (look & hit & ~lim_fail & ~perm_fail) begin
        mapped_addr_out <= phys;
      end
    end
  end

  // ----------------------------------------------------------------
  // effective ring and fetch tracking
  // ----------------------------------------------------------------
  always @* begin
    eff_ring_next = eff_ring_reg;
    fetch_next = fetch_reg;
    if ((fctl & `FPM_FC_ZERO_MASK) == `FPM_FC_ZERO) begin
      eff_ring_next = `FPM_RING_RST;
    end else if (fctl == `FPM_FC_START) begin
      fetch_next = 1'b1;
      eff_ring_next = cur_ring;
    end else if (fctl == `FPM_FC_END) begin
      fetch_next = 1'b0;
      eff_ring_next = cur_ring;
    end else if (fctl == `FPM_FC_INDIR) begin
      eff_ring_next = fpm_ring_max(eff_ring_reg, caller_ring_reg);
    end else if (look & hit & ~fetch_reg) begin
      eff_ring_next = fpm_ring_max(fpm_ring_max(eff_ring_reg, cur_ring), ent_ring);
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      eff_ring_reg <= `FPM_RING_RST;
      fetch_reg <= 1'b0;
      eff_ring_out <= `FPM_RING_RST;
      in_fetch <= 1'b0;
    end else begin
      eff_ring_reg <= eff_ring_next;
      fetch_reg <= fetch_next;
      eff_ring_out <= eff_ring_next;
      in_fetch <= fetch_next;
    end
  end

  // ----------------------------------------------------------------
  // ring transfer bits
  // ----------------------------------------------------------------
  // cpu must not drive while ring_drive is high, or the bits fight
  always @(posedge clock) begin
    if (!resetn) begin
      caller_ring_reg <= `FPM_RING_RST;
      caller_ring_out <= `FPM_RING_RST;
      xfer_oe_reg <= 1'b0;
    end else begin
      xfer_oe_reg <= ring_drive;
      if (ring_load & ~ring_drive) begin
        caller_ring_reg <= xfer_in;
        caller_ring_out <= xfer_in;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_xfer
      always @(posedge clock) begin
        if (!resetn) begin
          xfer_out_reg[gi] <= 1'b0;
        end else begin
          xfer_out_reg[gi] <= eff_ring_next[gi];
        end
      end
    end
  endgenerate

  assign ring_xfer_bit_hi_out = xfer_out_reg[1];
  assign ring_xfer_bit_lo_out = xfer_out_reg[0];
  assign ring_xfer_bit_hi_oe = xfer_oe_reg;
  assign ring_xfer_bit_lo_oe = xfer_oe_reg;

  // ----------------------------------------------------------------
  // open-collector stall and trap lines
  // ----------------------------------------------------------------
  // lines only ever pull low; release lets the wired pull-up take them high
  always @(posedge clock) begin
    if (!resetn) begin
      clock_stall_n_out <= 1'b0;
      clock_stall_n_oe <= 1'b0;
      trap_request_n_out <= 1'b0;
      trap_request_n_oe <= 1'b0;
      stall_seen <= 1'b0;
      trap_seen <= 1'b0;
      call_step <= 1'b0;
      return_step <= 1'b0;
      special_step <= 1'b0;
    end else begin
      clock_stall_n_oe <= (state_next == ST_MISS);
      trap_request_n_oe <= pm_trap_req;
      stall_seen <= ~clock_stall_n_in;
      trap_seen <= ~trap_request_n_in;
      call_step <= fw_call;
      return_step <= fw_return;
      special_step <= fw_special;
    end
  end
endmodule // fpm_mapper

`default_nettype wire

// ---- rtl/fpm_consts.vh ----
`ifndef FPM_CONSTS_VH
`define FPM_CONSTS_VH

// ----------------------------------------------------------------
// address widths and fields
// ----------------------------------------------------------------
`define FPM_VA_W 20
`define FPM_MAP_W 13
`define FPM_SEG_OFS_W 11
`define FPM_PAGE_OFS_W 7
`define FPM_IDX_W 5
`define FPM_DEPTH 32
`define FPM_IDX_LSB 11
`define FPM_SEGHI_LSB 16
`define FPM_PAGE_LSB 7
`define FPM_CS_W 10

// ----------------------------------------------------------------
// descriptor cache entry layout
// ----------------------------------------------------------------
`define FPM_ENT_W 39
`define FPM_ENT_VALID 38
`define FPM_ENT_PAGED 37
`define FPM_ENT_SEGHI_HI 36
`define FPM_ENT_SEGHI_LO 33
`define FPM_ENT_PAGE_HI 32
`define FPM_ENT_PAGE_LO 29
`define FPM_ENT_BASE_HI 28
`define FPM_ENT_BASE_LO 16
`define FPM_ENT_LIM_HI 15
`define FPM_ENT_LIM_LO 5
`define FPM_ENT_READ 4
`define FPM_ENT_WRITE 3
`define FPM_ENT_EXEC 2
`define FPM_ENT_RING_HI 1
`define FPM_ENT_RING_LO 0

// ----------------------------------------------------------------
// fetch control encodings {select, code0, code1, code2}
// ----------------------------------------------------------------
`define FPM_FC_START 4'h_b
`define FPM_FC_END 4'h_a
`define FPM_FC_INDIR 4'h_9
`define FPM_FC_ZERO_MASK 4'h_c
`define FPM_FC_ZERO 4'h_c

// ----------------------------------------------------------------
// firmware step addresses
// ----------------------------------------------------------------
`define FPM_CS_CALL 10'h_040
`define FPM_CS_RETURN 10'h_080
`define FPM_CS_SPECIAL_MASK 10'h_3c0
`define FPM_CS_SPECIAL_BASE 10'h_3c0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FPM_RING_RST 2'h_0
`define FPM_MAP_RST 13'h_0000

`endif

// ---- rtl/fpm_desc_mem.v ----
`timescale 1ns/1ps
`default_nettype none
`include "fpm_consts.vh"

module fpm_desc_mem (
  input wire clock,
  input wire resetn,
  input wire wr_en,
  input wire [`FPM_IDX_W-1:0] wr_addr,
  input wire [`FPM_ENT_W-1:0] wr_data,
  input wire [`FPM_IDX_W-1:0] rd_addr,
  output reg [`FPM_ENT_W-1:0] rd_data
);
  reg [`FPM_ENT_W-1:0] mem [0:`FPM_DEPTH-1];
  reg [`FPM_DEPTH-1:0] valid_reg;

  // valid bits live in flops so reset empties the cache without a sweep
  always @(posedge clock) begin
    if (!resetn) begin
      valid_reg <= {`FPM_DEPTH{1'b0}};
    end else if (wr_en) begin
      valid_reg[wr_addr] <= wr_data[`FPM_ENT_VALID];
    end
  end

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always @(posedge clock) begin
    if (!resetn) begin
      rd_data <= {`FPM_ENT_W{1'b0}};
    end else begin
      rd_data <= mem[rd_addr];
      rd_data[`FPM_ENT_VALID] <= valid_reg[rd_addr];
    end
  end
endmodule // fpm_desc_mem

`default_nettype wire

// ---- rtl/fpm_fw_detect.v ----
`timescale 1ns/1ps
`default_nettype none
`include "fpm_consts.vh"

module fpm_fw_detect (
  input wire clock,
  input wire resetn,
  input wire [`FPM_CS_W-1:0] cs_addr,
  output reg call_step,
  output reg return_step,
  output reg special_step
);
  always @(posedge clock) begin
    if (!resetn) begin
      call_step <= 1'b0;
      return_step <= 1'b0;
      special_step <= 1'b0;
    end else begin
      call_step <= (cs_addr == `FPM_CS_CALL);
      return_step <= (cs_addr == `FPM_CS_RETURN);
      special_step <= ((cs_addr & `FPM_CS_SPECIAL_MASK) == `FPM_CS_SPECIAL_BASE);
    end
  end
endmodule // fpm_fw_detect

`default_nettype wire

// ---- testbench/fpm_mapper_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpm_consts.vh"

module fpm_mapper_checker (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ref_valid,
  input wire logic [`FPM_CS_W-1:0] control_store_addr,
  input wire logic [1:0] cur_ring,
  input wire logic fetch_ctl_select,
  input wire logic fetch_func_code0,
  input wire logic fetch_func_code1,
  input wire logic fetch_func_code2,
  input wire logic ring_drive,
  input wire logic pm_trap_req,
  input wire logic ring_xfer_bit_hi_out,
  input wire logic ring_xfer_bit_hi_oe,
  input wire logic ring_xfer_bit_lo_out,
  input wire logic ring_xfer_bit_lo_oe,
  input wire logic clock_stall_n_out,
  input wire logic clock_stall_n_oe,
  input wire logic trap_request_n_out,
  input wire logic trap_request_n_oe,
  input wire logic [`FPM_MAP_W-1:0] mapped_addr_out,
  input wire logic map_valid,
  input wire logic tag_equal,
  input wire logic miss_req,
  input wire logic limit_err,
  input wire logic perm_err,
  input wire logic [1:0] eff_ring_out,
  input wire logic in_fetch,
  input wire logic call_step,
  input wire logic special_step
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic [3:0] fctl;
  assign fctl = {fetch_ctl_select, fetch_func_code0, fetch_func_code1, fetch_func_code2};
  sequence s_result; map_valid || tag_equal || miss_req; endsequence
  sequence s_special; control_store_addr[9:6] == 4'h_f; endsequence

  a_result_latency: assert property (s_result |-> $past(ref_valid, 2))
    else $error("lookup result without a request two cycles before");
  a_miss_clean: assert property (miss_req |-> !map_valid && !tag_equal && !limit_err
    && !perm_err && $stable(mapped_addr_out)) else $error("miss produced a mapping");
  a_miss_stalls: assert property (miss_req |-> clock_stall_n_oe && !clock_stall_n_out)
    else $error("miss without clock stall");
  a_addr_holds: assert property (!map_valid |-> $stable(mapped_addr_out))
    else $error("mapped address moved without a clean hit");
  a_err_on_hit: assert property ((limit_err || perm_err) |-> tag_equal && !map_valid)
    else $error("error flag outside a failing hit");
  a_trap_follow: assert property (1'b1 |=> trap_request_n_oe == $past(pm_trap_req)
    && !trap_request_n_out) else $error("trap line does not follow its request");
  a_zero_ring: assert property (fctl[3:2] == 2'b11 |=> eff_ring_out == 2'h_0)
    else $error("ring not forced to zero");
  a_fetch_ring: assert property (fctl == `FPM_FC_START |=> in_fetch
    && eff_ring_out == $past(cur_ring)) else $error("fetch start ring wrong");
  a_ring_drive: assert property (ring_drive |=> ring_xfer_bit_hi_oe && ring_xfer_bit_lo_oe
    && {ring_xfer_bit_hi_out, ring_xfer_bit_lo_out} == eff_ring_out)
    else $error("ring bits not driven with the ring");
  a_ring_float: assert property (!ring_drive |=> !(ring_xfer_bit_hi_oe || ring_xfer_bit_lo_oe))
    else $error("ring bits driven while not transferring");
  a_fw_call: assert property (control_store_addr == `FPM_CS_CALL |-> ##2 call_step)
    else $error("call step missed");
  a_fw_special: assert property (s_special |-> ##2 special_step)
    else $error("special step missed");
endmodule // fpm_mapper_checker

bind fpm_mapper fpm_mapper_checker u_fpm_mapper_checker (.clock, .resetn, .ref_valid,
  .control_store_addr, .cur_ring, .fetch_ctl_select, .fetch_func_code0, .fetch_func_code1,
  .fetch_func_code2, .ring_drive, .pm_trap_req, .ring_xfer_bit_hi_out, .ring_xfer_bit_hi_oe,
  .ring_xfer_bit_lo_out, .ring_xfer_bit_lo_oe, .clock_stall_n_out, .clock_stall_n_oe,
  .trap_request_n_out, .trap_request_n_oe, .mapped_addr_out, .map_valid, .tag_equal,
  .miss_req, .limit_err, .perm_err, .eff_ring_out, .in_fetch, .call_step, .special_step);
`default_nettype wire

// ---- testbench/fpm_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module fpm_cpu_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic stall_oe,
  input wire logic trap_oe,
  input wire logic [1:0] map_ring_out,
  input wire logic [1:0] map_ring_oe,
  input wire logic cpu_ring_drive,
  input wire logic [1:0] cpu_ring_val,
  input wire logic [3:0] resp_delay,
  output logic stall_line_n,
  output logic trap_line_n,
  output logic [1:0] ring_bits,
  output logic pm_resolve
);
  // ----------------------------------------------------------------
  // wired lines and miss mediation
  // ----------------------------------------------------------------
  logic [1:0] ring_last_reg = 2'h_0;
  logic [3:0] wait_reg = 4'h_0;
  // pulled-up open-collector lines read high once released
  assign stall_line_n = !stall_oe;
  assign trap_line_n = !trap_oe;
  // an undriven ring bit flips each cycle so a stale value never reads as valid
  assign ring_bits = (map_ring_oe & map_ring_out)
    | (~map_ring_oe & (cpu_ring_drive ? cpu_ring_val : ~ring_last_reg));
  // a miss is settled after resp_delay stalled cycles, prompt or slow
  assign pm_resolve = !stall_line_n && (wait_reg == resp_delay);

  always @(posedge clock) begin
    ring_last_reg <= ring_bits;
    wait_reg <= (stall_line_n || !resetn) ? 4'h_0 : wait_reg + 4'h_1;
  end
endmodule // fpm_cpu_model
`default_nettype wire

// ---- testbench/test_fpm_mapper.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fpm_consts.vh"
`define CHECK_EQ(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module test_fpm_mapper;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clock = 1'b0, resetn = 1'b0, ref_valid = 1'b0, req_read = 1'b0, req_write = 1'b0;
  logic req_exec = 1'b0, fetch_ctl_select = 1'b0, fetch_func_code0 = 1'b0;
  logic fetch_func_code1 = 1'b0, fetch_func_code2 = 1'b0, ring_drive = 1'b0, ring_load = 1'b0;
  logic desc_wr_en = 1'b0, pm_trap_req = 1'b0, cpu_ring_drive = 1'b0, seen;
  logic [19:0] virt_addr_in = 20'h_0_0000;
  logic [1:0] cur_ring = 2'h_0, cpu_ring_val = 2'h_0, eff_ring_out, caller_ring_out, ring_bits;
  logic [9:0] control_store_addr = 10'h_000;
  logic [4:0] desc_wr_index = 5'h_00;
  logic [38:0] desc_wr_data = 39'h_00_0000_0000;
  logic [3:0] resp_delay = 4'h_0;
  logic [12:0] mapped_addr_out;
  logic [2:0] fw_exp;
  logic ring_xfer_bit_hi_out, ring_xfer_bit_hi_oe, ring_xfer_bit_lo_out, ring_xfer_bit_lo_oe;
  logic clock_stall_n_out, clock_stall_n_oe, trap_request_n_out, trap_request_n_oe, map_valid;
  logic tag_equal, miss_req, limit_err, perm_err, in_fetch, stall_seen, trap_seen, call_step;
  logic return_step, special_step, stall_line_n, trap_line_n, pm_resolve;
  logic [3:0] delays [2] = '{4'h_0, 4'h_6};
  logic [9:0] fw_addr [4] = '{10'h_040, 10'h_080, 10'h_3c5, 10'h_041};
  int bad_count = 0, comparisons = 0, n;

  fpm_mapper u_fpm_mapper (.clock, .resetn, .ref_valid, .virt_addr_in, .req_read, .req_write,
    .req_exec, .cur_ring, .fetch_ctl_select, .fetch_func_code0, .fetch_func_code1,
    .fetch_func_code2, .control_store_addr, .ring_drive, .ring_load,
    .ring_xfer_bit_hi_in(ring_bits[1]), .ring_xfer_bit_hi_out, .ring_xfer_bit_hi_oe,
    .ring_xfer_bit_lo_in(ring_bits[0]), .ring_xfer_bit_lo_out, .ring_xfer_bit_lo_oe,
    .desc_wr_en, .desc_wr_index, .desc_wr_data, .pm_resolve, .pm_trap_req,
    .clock_stall_n_in(stall_line_n), .clock_stall_n_out, .clock_stall_n_oe,
    .trap_request_n_in(trap_line_n), .trap_request_n_out, .trap_request_n_oe,
    .mapped_addr_out, .map_valid, .tag_equal, .miss_req, .limit_err, .perm_err, .eff_ring_out,
    .caller_ring_out, .in_fetch, .stall_seen, .trap_seen, .call_step, .return_step,
    .special_step);

  fpm_cpu_model u_fpm_cpu_model (.clock, .resetn, .stall_oe(clock_stall_n_oe),
    .trap_oe(trap_request_n_oe), .map_ring_out({ring_xfer_bit_hi_out, ring_xfer_bit_lo_out}),
    .map_ring_oe({ring_xfer_bit_hi_oe, ring_xfer_bit_lo_oe}), .cpu_ring_drive, .cpu_ring_val,
    .resp_delay, .stall_line_n, .trap_line_n, .ring_bits, .pm_resolve);

  always #12.5 clock = ~clock;

  // ----------------------------------------------------------------
  // access tasks; each starts and ends 2 ns after a rising edge
  // ----------------------------------------------------------------
  task tick(input int cycles);
    repeat (cycles) @(posedge clock);
    #2;
  endtask

  function automatic logic [38:0] ent(input logic pg, input logic [3:0] sh, input logic [3:0] pn,
    input logic [12:0] base, input logic [10:0] lim, input logic [2:0] rwe, input logic [1:0] rg);
    return {1'b1, pg, sh, pn, base, lim, rwe, rg};
  endfunction

  function automatic logic [19:0] pva(input logic [6:0] off);
    return {4'h_2, 5'h_04, 4'h_9, off};
  endfunction

  task fill(input logic [4:0] idx, input logic [38:0] data);
    {desc_wr_en, desc_wr_index, desc_wr_data} = {1'b1, idx, data};
    tick(1);
    desc_wr_en = 1'b0;
    tick(1);
  endtask

  // result flags are {map_valid, tag_equal, limit_err, perm_err, miss_req}
  task look(input logic [19:0] va, input logic [2:0] rwe, input logic [4:0] exp);
    {virt_addr_in, req_read, req_write, req_exec, ref_valid} = {va, rwe, 1'b1};
    tick(1);
    ref_valid = 1'b0;
    tick(1);
    `CHECK_EQ({map_valid, tag_equal, limit_err, perm_err, miss_req}, exp);
  endtask

  task ctl(input logic [3:0] code);
    {fetch_ctl_select, fetch_func_code0, fetch_func_code1, fetch_func_code2} = code;
    tick(1);
    {fetch_ctl_select, fetch_func_code0, fetch_func_code1, fetch_func_code2} = 4'h_0;
  endtask

  task give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    give_verdict;
  end

  initial begin
    repeat (20) @(posedge clock);
    #2;
    resetn = 1'b1;
    tick(1);
    `CHECK_EQ({map_valid, miss_req, clock_stall_n_oe, trap_request_n_oe, eff_ring_out}, 6'h_00);
    `CHECK_EQ(mapped_addr_out, 13'h_0000);
    fill(5'h_03, ent(1'b0, 4'h_5, 4'h_0, 13'h_0100, 11'h_7ff, 3'h_7, 2'h_3));
    fill(5'h_04, ent(1'b1, 4'h_2, 4'h_9, 13'h_1ff0, 11'h_040, 3'h_4, 2'h_1));
    ctl(4'h_c);
    `CHECK_EQ(eff_ring_out, 2'h_0);
    look(pva(7'h_40), 3'h_4, 5'h_18);
    `CHECK_EQ(mapped_addr_out, 13'h_0030);
    look(pva(7'h_41), 3'h_4, 5'h_0c);
    look(pva(7'h_10), 3'h_2, 5'h_0a);
    `CHECK_EQ(mapped_addr_out, 13'h_0030);
    look({4'h_5, 5'h_03, 11'h_7ff}, 3'h_1, 5'h_18);
    `CHECK_EQ(mapped_addr_out, 13'h_08ff);
    tick(1);
    `CHECK_EQ(eff_ring_out, 2'h_3);
    ctl(4'h_f);
    `CHECK_EQ(eff_ring_out, 2'h_0);
    cur_ring = 2'h_2;
    ctl(`FPM_FC_START);
    `CHECK_EQ({in_fetch, eff_ring_out}, 3'h_6);
    look(pva(7'h_20), 3'h_4, 5'h_0a);
    cur_ring = 2'h_1;
    look(pva(7'h_20), 3'h_4, 5'h_18);
    `CHECK_EQ(mapped_addr_out, 13'h_0010);
    ctl(`FPM_FC_END);
    `CHECK_EQ({in_fetch, eff_ring_out}, 3'h_1);
    {cpu_ring_drive, cpu_ring_val, ring_load} = 4'h_d;
    tick(1);
    {cpu_ring_drive, ring_load} = 2'h_0;
    `CHECK_EQ(caller_ring_out, 2'h_2);
    ctl(`FPM_FC_INDIR);
    `CHECK_EQ(eff_ring_out, 2'h_2);
    ring_drive = 1'b1;
    tick(1);
    `CHECK_EQ({ring_xfer_bit_hi_oe, ring_xfer_bit_lo_oe, ring_bits}, 4'h_e);
    ring_drive = 1'b0;
    tick(1);
    `CHECK_EQ({ring_xfer_bit_hi_oe, ring_xfer_bit_lo_oe}, 2'h_0);
    foreach (delays[i]) begin
      resp_delay = delays[i];
      look({4'h_7, 5'h_03, 11'h_000}, 3'h_4, 5'h_01);
      `CHECK_EQ(mapped_addr_out, 13'h_0010);
      seen = 1'b0;
      n = 0;
      do begin
        tick(1);
        seen = seen | stall_seen;
        n++;
      end while (clock_stall_n_oe && n < 40);
      `CHECK_EQ({seen, clock_stall_n_oe}, 2'h_2);
    end
    pm_trap_req = 1'b1;
    tick(2);
    `CHECK_EQ({trap_seen, trap_line_n}, 2'h_2);
    pm_trap_req = 1'b0;
    tick(2);
    `CHECK_EQ({trap_seen, trap_line_n}, 2'h_1);
    foreach (fw_addr[i]) begin
      control_store_addr = fw_addr[i];
      fw_exp = {fw_addr[i] == `FPM_CS_CALL, fw_addr[i] == `FPM_CS_RETURN, fw_addr[i][9:6] == 4'h_f};
      tick(2);
      `CHECK_EQ({call_step, return_step, special_step}, fw_exp);
    end
    give_verdict;
  end
endmodule // test_fpm_mapper
`default_nettype wire
